// >>> core/overcurrent_defines.svh
// offsets, field positions, reset values and filter constants of the overcurrent comparator
`ifndef OVERCURRENT_DEFINES_SVH
`define OVERCURRENT_DEFINES_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define OC_ADDR_W          8
`define OC_DATA_W          16
`define OC_CFG_ADDR        8'h87
`define OC_HIGH_ADDR       8'h88
`define OC_LOW_ADDR        8'h89
`define OC_CFG_RESET       16'h0000
`define OC_HIGH_RESET      16'h7FFF
`define OC_LOW_RESET       16'h8000

// ---------------------------------------------------------------
// config field positions
// ---------------------------------------------------------------
`define OC_CFG_EN_BIT      15
`define OC_CFG_POL_BIT     14
`define OC_CFG_RSV_BIT     13
`define OC_CFG_NUM_HI      12
`define OC_CFG_NUM_LO      8
`define OC_CFG_LOW_ZERO    8'h00

// ---------------------------------------------------------------
// fast filter and comparison
// ---------------------------------------------------------------
`define OC_OSR             64
`define OC_DEC_W           6
`define OC_DEC_LAST        6'h3F
`define OC_ACC_W           21
`define OC_OUT_SHIFT       3
`define OC_POS_FS          16'h7FFF
`define OC_NEG_FS          16'h8000
`define OC_SAT_HI          21'h007FFF
`define OC_SAT_LO          21'h1F8000
`define OC_WARM_W          2
`define OC_WARM_DONE       2'h3
`define OC_CNT_W           8

`endif

// >>> core/overcurrent_pkg.sv
// types shared by the overcurrent comparator
package overcurrent_pkg;

	// comparator configuration word
	typedef struct packed {
		logic       enable;
		logic       polarity;
		logic       reserved;
		logic [4:0] count_select;
	} cfg_s;

	// shared pin setup coming from the pin multiplexer
	typedef struct packed {
		logic source_select;
		logic open_drain;
	} pin_cfg_s;

	// fault flags, index 0 high limit, index 1 low limit
	typedef logic [1:0] flags_t;

endpackage : overcurrent_pkg

// >>> core/overcurrent_comparator.sv
// overcurrent comparator: sinc3 fast filter, two limit comparators, deglitch, fault pin
`timescale 1ns/1ns
`include "overcurrent_defines.svh"

// Notes on behaviour
// R1: filter and comparator run only while config bit 15 is set; resets to off.
// R2: host keeps the shunt channel enabled whenever it uses the comparator.
// R3: conversion start and stop bits neither start nor halt the fast filter.
// R4: polarity bit 14 zero drives pin low on fault, one drives it high.
// R5: fault is active when the high flag or the low flag is active.
// R6: pin carries fault only when source select picks it; format shapes drive.
// R7: bits 12..8 choose consecutive conversions needed, code 0 one, top code 128.
// R8: fast filter is third order sinc with fixed oversampling ratio 64.
// R9: deglitch count restarts at zero once output is inside the limit.
// R10: high limit is a 16-bit two's complement value.
// R11: high event when filter output strictly above high limit for chosen count.
// R12: high limit at positive full scale disables high detection; reset value.
// R13: low event when output strictly below low limit; negative full scale disables.
// R14: 16-bit signed output compared once per conversion; counters step only then.
// R15: host writes zero to reserved bit 13; low byte reads zero.
module overcurrent_comparator (
	input  wire logic                        CLK_I,
	input  wire logic                        RSTN_I,
	input  wire logic                        MOD_BIT_I,
	input  wire logic                        CHAN_EN_I,
	input  wire overcurrent_pkg::pin_cfg_s   PIN_CFG_I,
	input  wire logic [`OC_ADDR_W-1:0]       REG_ADDR_I,
	input  wire logic [`OC_DATA_W-1:0]       REG_WDATA_I,
	input  wire logic                        REG_WR_I,
	input  wire logic                        REG_RD_I,
	output logic      [`OC_DATA_W-1:0]       REG_RDATA_O,
	output logic                             FAULT_PIN_O,
	output logic                             FAULT_PIN_OE_O,
	output overcurrent_pkg::flags_t          FLAGS_O,
	output logic                             FAULT_ACTIVE_O
);
	import overcurrent_pkg::*;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	cfg_s                   cfg_reg,   cfg_next;
	logic [`OC_DATA_W-1:0]  high_reg,  high_next;
	logic [`OC_DATA_W-1:0]  low_reg,   low_next;
	logic [`OC_DATA_W-1:0]  rdata_reg, rdata_next;

	// config reset held as a full word so the stored field slice is cut on purpose
	localparam logic [`OC_DATA_W-1:0] cfg_rst_word = `OC_CFG_RESET;

	// writes land on the named offsets; unmapped reads answer zero
	always_comb begin
		cfg_next   = cfg_reg;
		high_next  = high_reg;
		low_next   = low_reg;
		rdata_next = rdata_reg;
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				`OC_CFG_ADDR: begin
					cfg_next.enable       = REG_WDATA_I[`OC_CFG_EN_BIT];  // R1
					cfg_next.polarity     = REG_WDATA_I[`OC_CFG_POL_BIT];
					cfg_next.reserved     = REG_WDATA_I[`OC_CFG_RSV_BIT]; // R15
					cfg_next.count_select = REG_WDATA_I[`OC_CFG_NUM_HI:`OC_CFG_NUM_LO];
				end
				`OC_HIGH_ADDR: high_next = REG_WDATA_I; // R10
				`OC_LOW_ADDR:  low_next  = REG_WDATA_I;
				default: ;
			endcase
		end
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				`OC_CFG_ADDR:  rdata_next = {cfg_reg, `OC_CFG_LOW_ZERO}; // R15
				`OC_HIGH_ADDR: rdata_next = high_reg;
				`OC_LOW_ADDR:  rdata_next = low_reg;
				default:       rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg_reg   <= cfg_rst_word[`OC_DATA_W-1:`OC_CFG_NUM_LO];
			high_reg  <= `OC_HIGH_RESET; // R12
			low_reg   <= `OC_LOW_RESET;
			rdata_reg <= '0;
		end else begin
			cfg_reg   <= cfg_next;
			high_reg  <= high_next;
			low_reg   <= low_next;
			rdata_reg <= rdata_next;
		end
	end

	// ---------------------------------------------------------------
	// sinc3 fast filter
	// ---------------------------------------------------------------
	// runs from the modulator bit alone; start/stop of the main path never reach it
	logic                          run;
	logic signed [`OC_ACC_W-1:0]   in_step;
	logic signed [`OC_ACC_W-1:0]   i1_reg, i2_reg, i3_reg, i1_next, i2_next, i3_next;
	logic signed [`OC_ACC_W-1:0]   d1_reg, d2_reg, d3_reg, d1_next, d2_next, d3_next;
	logic signed [`OC_ACC_W-1:0]   c1, c2, c3, scaled;
	logic        [`OC_DEC_W-1:0]   dec_reg, dec_next;
	logic        [`OC_WARM_W-1:0]  warm_reg, warm_next;
	logic signed [`OC_DATA_W-1:0]  data_reg, data_next;
	logic                          conv_reg, conv_next;

	assign run     = cfg_reg.enable && CHAN_EN_I; // R1 R2 R3
	assign in_step = MOD_BIT_I ? `OC_ACC_W'sd1 : -`OC_ACC_W'sd1;

	// integrators every clock, combs once per 64 bits; wrap-around arithmetic is intended
	always_comb begin
		i1_next   = i1_reg;
		i2_next   = i2_reg;
		i3_next   = i3_reg;
		d1_next   = d1_reg;
		d2_next   = d2_reg;
		d3_next   = d3_reg;
		dec_next  = dec_reg;
		warm_next = warm_reg;
		data_next = data_reg;
		conv_next = 1'b0;
		c1        = i3_reg - d1_reg;
		c2        = c1 - d2_reg;
		c3        = c2 - d3_reg;
		scaled    = c3 >>> `OC_OUT_SHIFT;
		if (!run) begin
			i1_next   = '0;
			i2_next   = '0;
			i3_next   = '0;
			d1_next   = '0;
			d2_next   = '0;
			d3_next   = '0;
			dec_next  = '0;
			warm_next = '0;
		end else begin
			i1_next  = i1_reg + in_step; // R8
			i2_next  = i2_reg + i1_reg;
			i3_next  = i3_reg + i2_reg;
			dec_next = dec_reg + `OC_DEC_W'd1;
			if (dec_reg == `OC_DEC_LAST) begin
				d1_next = i3_reg; // R8
				d2_next = c1;
				d3_next = c2;
				// first combs hold start-up garbage, so they are not compared
				if (warm_reg != `OC_WARM_DONE)
					warm_next = warm_reg + `OC_WARM_W'd1;
				else
					conv_next = 1'b1; // R14
				// full scale 2^18 lands one past +FS, so clamp both ends
				if (scaled > $signed(`OC_SAT_HI))
					data_next = `OC_POS_FS;
				else if (scaled < $signed(`OC_SAT_LO))
					data_next = `OC_NEG_FS;
				else
					data_next = scaled[`OC_DATA_W-1:0]; // R14
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			i1_reg   <= '0;
			i2_reg   <= '0;
			i3_reg   <= '0;
			d1_reg   <= '0;
			d2_reg   <= '0;
			d3_reg   <= '0;
			dec_reg  <= '0;
			warm_reg <= '0;
			data_reg <= '0;
			conv_reg <= 1'b0;
		end else begin
			i1_reg   <= i1_next;
			i2_reg   <= i2_next;
			i3_reg   <= i3_next;
			d1_reg   <= d1_next;
			d2_reg   <= d2_next;
			d3_reg   <= d3_next;
			dec_reg  <= dec_next;
			warm_reg <= warm_next;
			data_reg <= data_next;
			conv_reg <= conv_next;
		end
	end

	// ---------------------------------------------------------------
	// limit comparators with deglitch
	// ---------------------------------------------------------------
	// count select to required conversions
	function automatic logic [`OC_CNT_W-1:0] needed(input logic [4:0] code);
		logic [`OC_CNT_W-1:0] n;
		n = '0;
		unique case (code)
			5'h0A: n = 8'h0C; 5'h0B: n = 8'h0E; 5'h0C: n = 8'h10; 5'h0D: n = 8'h12;
			5'h0E: n = 8'h14; 5'h0F: n = 8'h16; 5'h10: n = 8'h18; 5'h11: n = 8'h1C;
			5'h12: n = 8'h20; 5'h13: n = 8'h28; 5'h14: n = 8'h30; 5'h15: n = 8'h34;
			5'h16: n = 8'h38; 5'h17: n = 8'h40; 5'h18: n = 8'h48; 5'h19: n = 8'h50;
			5'h1A: n = 8'h58; 5'h1B: n = 8'h60; 5'h1C: n = 8'h68; 5'h1D: n = 8'h70;
			5'h1E: n = 8'h78; 5'h1F: n = 8'h80;
			default: n = {3'h0, code} + 8'h01; // codes 0..9 give 1..10
		endcase
		return n;
	endfunction : needed

	logic [`OC_CNT_W-1:0] need;
	logic [1:0]           armed, exceed;
	logic [`OC_CNT_W-1:0] cnt_reg  [2];
	logic [`OC_CNT_W-1:0] cnt_next [2];
	flags_t               flag_reg, flag_next;

	assign need      = needed(cfg_reg.count_select); // R7
	assign armed[0]  = high_reg != `OC_POS_FS; // R12
	assign armed[1]  = low_reg  != `OC_NEG_FS; // R13
	assign exceed[0] = armed[0] && (data_reg > $signed(high_reg)); // R11 R10
	assign exceed[1] = armed[1] && (data_reg < $signed(low_reg));  // R13

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_limit
			// no hysteresis: any in-range conversion drops count and flag
			always_comb begin
				cnt_next[g]  = cnt_reg[g];
				flag_next[g] = flag_reg[g];
				if (!run || !armed[g]) begin
					cnt_next[g]  = '0; // R1
					flag_next[g] = 1'b0;
				end else if (conv_reg) begin // R14
					if (exceed[g]) begin
						if (cnt_reg[g] < need)
							cnt_next[g] = cnt_reg[g] + `OC_CNT_W'd1;
						flag_next[g] = ({1'b0, cnt_reg[g]} + 9'h001) >= {1'b0, need}; // R7
					end else begin
						cnt_next[g]  = '0; // R9
						flag_next[g] = 1'b0;
					end
				end
			end

			always_ff @(posedge CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					cnt_reg[g]  <= '0;
					flag_reg[g] <= 1'b0;
				end else begin
					cnt_reg[g]  <= cnt_next[g];
					flag_reg[g] <= flag_next[g];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// fault pin
	// ---------------------------------------------------------------
	logic fault, level;
	logic pin_next, oe_next;

	assign fault = |flag_reg;                          // R5
	assign level = cfg_reg.polarity ? fault : !fault;  // R4

	// open drain only pulls low, so a high level means releasing the pin
	always_comb begin
		pin_next = 1'b0;
		oe_next  = 1'b0;
		if (PIN_CFG_I.source_select) begin // R6
			if (PIN_CFG_I.open_drain)
				oe_next = !level;
			else begin
				pin_next = level;
				oe_next  = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FAULT_PIN_O    <= 1'b0;
			FAULT_PIN_OE_O <= 1'b0;
			FAULT_ACTIVE_O <= 1'b0;
		end else begin
			FAULT_PIN_O    <= pin_next;
			FAULT_PIN_OE_O <= oe_next;
			FAULT_ACTIVE_O <= fault;
		end
	end

	assign REG_RDATA_O = rdata_reg;
	assign FLAGS_O     = flag_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	disabled_clear_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R1
		!cfg_reg.enable |=> flag_reg == 2'b00 && cnt_reg[0] == '0)
		else $error("flags not cleared while comparator is off");
	high_off_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R12
		(high_reg == `OC_POS_FS) |=> !flag_reg[0])
		else $error("high flag set with high limit at full scale");
	low_off_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R13
		(low_reg == `OC_NEG_FS) |=> !flag_reg[1])
		else $error("low flag set with low limit at full scale");
	pin_level_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R4
		(PIN_CFG_I.source_select && !PIN_CFG_I.open_drain) |=>
		FAULT_PIN_O == ($past(cfg_reg.polarity) ? $past(|flag_reg) : !$past(|flag_reg)))
		else $error("fault pin level does not follow polarity");
	fault_or_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R5
		1'b1 |=> FAULT_ACTIVE_O == $past(flag_reg != 2'b00))
		else $error("fault active does not follow the flags");
	pin_release_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R6
		!PIN_CFG_I.source_select |=> !FAULT_PIN_OE_O)
		else $error("pin driven while not selected");
	restart_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R9
		(conv_reg && !exceed[0]) |=> cnt_reg[0] == '0 && !flag_reg[0])
		else $error("deglitch count not restarted");
	count_hold_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R14
		(!conv_reg && run && armed[0] && $stable(high_reg)) |=> $stable(cnt_reg[0]))
		else $error("deglitch count moved between conversions");
	conv_period_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R8
		conv_reg |-> $past(dec_reg) == `OC_DEC_LAST)
		else $error("conversion not on the 64th modulator bit");
	trip_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R11
		$rose(flag_reg[0]) |-> $past(conv_reg) && $past(exceed[0]))
		else $error("high flag rose without an exceeding conversion");

endmodule : overcurrent_comparator

// >>> tb/fault_watcher.sv
// behavioural battery controller watching the shared fault pin
`timescale 1ns/1ns

module fault_watcher (
	input  wire logic pin_i,
	input  wire logic oe_i,
	input  wire logic active_high_i,
	output logic      wire_o,
	output logic      fault_seen_o
);
	// a released line floats up through the board pull-up, never keeps its last value
	assign wire_o = oe_i ? pin_i : 1'b1;
	// fault read against the polarity the controller was set up for
	assign fault_seen_o = (wire_o == active_high_i);
endmodule : fault_watcher

// >>> tb/overcurrent_comparator_tb.sv
// self-checking bench of the overcurrent comparator
`timescale 1ns/1ns
`include "overcurrent_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end

module overcurrent_comparator_tb;
	import overcurrent_pkg::*;
	// deglitch counts of codes 10 and up
	localparam int TAB [22] = '{12, 14, 16, 18, 20, 22, 24, 28, 32, 40, 48, 52, 56, 64, 72,
		80, 88, 96, 104, 112, 120, 128};
	logic        clk_i, rstn_i, mod_bit, chan_en, wr, rd, pin, oe, f_act, wire_lvl, seen;
	logic        pol;
	pin_cfg_s    pin_cfg;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, rv;
	flags_t      flags;
	int          bad_count, check_count, seed, t0, n;

	overcurrent_comparator u_dut (.CLK_I(clk_i), .RSTN_I(rstn_i), .MOD_BIT_I(mod_bit),
		.CHAN_EN_I(chan_en), .PIN_CFG_I(pin_cfg), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FAULT_PIN_O(pin),
		.FAULT_PIN_OE_O(oe), .FLAGS_O(flags), .FAULT_ACTIVE_O(f_act));
	fault_watcher u_bms (.pin_i(pin), .oe_i(oe), .active_high_i(pol), .wire_o(wire_lvl),
		.fault_seen_o(seen));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic int n_of(input logic [4:0] c);
		return (c < 10) ? int'(c) + 1 : TAB[c - 10];
	endfunction : n_of

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// strobes launched just after an edge, dropped after the taking edge
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i); #1;
		addr = a; wdata = d; wr = 1'b1;
		@(posedge clk_i); #1;
		wr = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i); #1;
		addr = a; rd = 1'b1;
		@(posedge clk_i); #1;
		rd = 1'b0;
		d = rdata;
	endtask : reg_rd

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		reg_rd(a, rv);
		`CHK(rv, e)
	endtask : chk_rd

	// bounded wait for one flag to reach a level, cycles counted
	task automatic wait_flag(input int b, input logic v, input int lim, output int k);
		k = 0;
		while (flags[b] !== v && k < lim) begin @(posedge clk_i); #1; k++; end
		if (flags[b] !== v) begin bad_count++; $display("unexpected at %0t: wait ran out", $time);
			give_verdict(); end
	endtask : wait_flag

	task automatic en_cfg(input logic p, input logic [4:0] c);
		pol = p;
		reg_wr(`OC_CFG_ADDR, {1'b1, p, 1'b0, c, 8'h00});
	endtask : en_cfg

	task automatic trip(input logic [4:0] c, output int k);
		en_cfg(1'b0, c);
		wait_flag(0, 1'b1, 9000, k);
		reg_wr(`OC_CFG_ADDR, 16'h0000);
		repeat (3) @(posedge clk_i);
		#1;
		`CHK(flags, 2'b00)
	endtask : trip

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rstn_i = 1'b0; mod_bit = 1'b1; chan_en = 1'b1; wr = 1'b0; rd = 1'b0; pol = 1'b0;
		pin_cfg = 2'b10; addr = 8'h00; wdata = 16'h0000; seed = 51406;
		bad_count = 0; check_count = 0;
		repeat (6) @(posedge clk_i);
		#1 rstn_i = 1'b1;
		chk_rd(`OC_CFG_ADDR, 16'h0000);
		chk_rd(`OC_HIGH_ADDR, 16'h7FFF);
		chk_rd(`OC_LOW_ADDR, 16'h8000);
		reg_wr(8'h8A, 16'h1234);
		chk_rd(8'h8A, 16'h0000);
		reg_wr(`OC_CFG_ADDR, 16'h5F5A);
		chk_rd(`OC_CFG_ADDR, 16'h5F00);
		for (int i = 0; i < 8; i++) begin
			wdata = 16'($random(seed));
			reg_wr(`OC_HIGH_ADDR + i[0], wdata);
			chk_rd(`OC_HIGH_ADDR + i[0], wdata);
		end
		reg_wr(`OC_LOW_ADDR, 16'h8000);
		reg_wr(`OC_HIGH_ADDR, 16'h4000);
		// trip delay grows by one conversion per extra deglitch step
		trip(5'd0, t0);
		for (int j = 0; j < 4; j++) begin
			logic [4:0] c;
			c = (j == 0) ? 5'd3 : (j == 1) ? 5'd9 : (j == 2) ? 5'd10 : 5'd31;
			trip(c, n);
			`CHK(n - t0, 64 * (n_of(c) - 1))
		end
		// count restarts once the output falls back inside the limit
		en_cfg(1'b0, 5'd3);
		wait_flag(0, 1'b1, 2000, n);
		mod_bit = 1'b0;
		wait_flag(0, 1'b0, 600, n);
		mod_bit = 1'b1;
		wait_flag(0, 1'b1, 2000, n);
		`CHK(n > 192, 1'b1)
		// full-scale high limit keeps detection off
		reg_wr(`OC_HIGH_ADDR, 16'h7FFF);
		en_cfg(1'b0, 5'd0);
		repeat (600) @(posedge clk_i);
		#1;
		`CHK(flags, 2'b00)
		`CHK({f_act, wire_lvl, seen}, 3'b010)
		// low trip, then every polarity, format and source combination
		reg_wr(`OC_LOW_ADDR, 16'hC000);
		mod_bit = 1'b0;
		wait_flag(1, 1'b1, 2000, n);
		for (int i = 0; i < 8; i++) begin
			pin_cfg = {i[2], i[1]};
			en_cfg(i[0], 5'd0);
			repeat (4) @(posedge clk_i);
			#1;
			`CHK(f_act, 1'b1)
			`CHK(oe, i[2] & (~i[1] | ~i[0]))
			`CHK(wire_lvl, i[2] ? i[0] : 1'b1)
			`CHK(seen, i[2] | i[0])
		end
		// channel off keeps the filter idle, turning it on starts it
		reg_wr(`OC_CFG_ADDR, 16'h0000);
		reg_wr(`OC_LOW_ADDR, 16'h8000);
		reg_wr(`OC_HIGH_ADDR, 16'h4000);
		chan_en = 1'b0;
		mod_bit = 1'b1;
		en_cfg(1'b0, 5'd0);
		repeat (600) @(posedge clk_i);
		#1;
		`CHK(flags, 2'b00)
		chan_en = 1'b1;
		wait_flag(0, 1'b1, 600, n);
		`CHK(n, t0)
		give_verdict();
	end
endmodule : overcurrent_comparator_tb
